// file: sad_bus_master.sv
// Bus master model standing in for the processor core and the DMA.
// Assumes the bench sets issue and issue_addr just after a falling edge.
`timescale 1ns/1ps
module sad_bus_master (
  input  wire logic        clk,
  input  wire logic        issue,
  input  wire logic [31:0] issue_addr,
  output logic             req_valid,
  output logic [31:0]      req_addr
);
  logic [31:0] last_r = 32'h0;
  // A released address bus shows the inverse of its last value.
  always @(posedge clk) begin
    if (issue) begin
      last_r <= issue_addr;
    end
  end
  assign req_valid = issue;
  assign req_addr  = issue ? issue_addr : ~last_r;
endmodule // sad_bus_master

// file: sad_decoder.sv
// First-level system bus address decoder with internal remap alias.
// Assumes masters hold req_addr valid with req_valid; boot select is an asynchronous level.
`timescale 1ns/1ps
module sad_decoder (
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  input  wire logic                      req_valid,
  input  wire logic [31:0]               req_addr,
  input  wire logic                      remap_cmd,
  input  wire logic                      boot_select_nv_bit,
  output logic                           resp_valid,
  output logic                           sel_flash,
  output logic                           sel_sram,
  output logic                           sel_rom,
  output logic [7:0]                     external_bus_interface_sel,
  output logic                           periph_sel,
  output logic                           abort,
  output logic [31:0]                    fwd_addr,
  output logic                           remap_state
);
  typedef struct packed {
    logic        boot_meta;
    logic        boot_sync;
    logic        remap;
    logic        resp_valid;
    logic        sel_flash;
    logic        sel_sram;
    logic        sel_rom;
    logic [7:0]  ext_sel;
    logic        periph_sel;
    logic        abort;
    logic [31:0] fwd_addr;
  } sad_state_type;

  sad_state_type           state_r;
  sad_state_type           state_nxt;
  logic [3:0]              area;
  logic [7:0]              slot;
  logic [7:0]              ext_hit;
  sad_pkg::sad_target_type int_target;

  assign area = req_addr[sad_pkg::AREA_MSB:sad_pkg::AREA_LSB];
  assign slot = req_addr[sad_pkg::SLOT_MSB:sad_pkg::SLOT_LSB];

  // One chip select per external area.
  for (genvar i = 0; i < sad_pkg::EXT_CS_COUNT; i++) begin : g_ext
    assign ext_hit[i] = (area == (sad_pkg::AREA_EXT_LO + 4'(i)));
  end

  sad_internal_slot u_slot (
    .slot       (slot),
    .remap      (state_r.remap),
    .boot_flash (state_r.boot_sync),
    .target     (int_target)
  );

  always_comb begin
    state_nxt            = state_r;
    state_nxt.boot_meta  = boot_select_nv_bit;
    state_nxt.boot_sync  = state_r.boot_meta;
    state_nxt.remap      = state_r.remap | remap_cmd;
    state_nxt.resp_valid = req_valid;
    state_nxt.sel_flash  = 1'b0;
    state_nxt.sel_sram   = 1'b0;
    state_nxt.sel_rom    = 1'b0;
    state_nxt.ext_sel    = 8'h00;
    state_nxt.periph_sel = 1'b0;
    state_nxt.abort      = 1'b0;
    state_nxt.fwd_addr   = req_addr;
    if (req_valid) begin
      if (area == sad_pkg::AREA_INTERNAL) begin
        state_nxt.sel_flash = (int_target == sad_pkg::SAD_TGT_FLASH);
        state_nxt.sel_sram  = (int_target == sad_pkg::SAD_TGT_SRAM);
        state_nxt.sel_rom   = (int_target == sad_pkg::SAD_TGT_ROM);
        state_nxt.abort     = (int_target == sad_pkg::SAD_TGT_NONE);
      end else if (area >= sad_pkg::AREA_EXT_LO && area <= sad_pkg::AREA_EXT_HI) begin
        state_nxt.ext_sel = ext_hit;
      end else if (area == sad_pkg::AREA_PERIPH) begin
        state_nxt.periph_sel = 1'b1;
      end else begin
        state_nxt.abort = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign resp_valid                 = state_r.resp_valid;
  assign sel_flash                  = state_r.sel_flash;
  assign sel_sram                   = state_r.sel_sram;
  assign sel_rom                    = state_r.sel_rom;
  assign external_bus_interface_sel = state_r.ext_sel;
  assign periph_sel                 = state_r.periph_sel;
  assign abort                      = state_r.abort;
  assign fwd_addr                   = state_r.fwd_addr;
  assign remap_state                = state_r.remap;

  property p_one_target;
    @(posedge clk) disable iff (sys_rst)
    req_valid |=> resp_valid
      && $onehot({sel_flash, sel_sram, sel_rom, external_bus_interface_sel, periph_sel, abort});
  endproperty
  a_one_target: assert property (p_one_target) else $error("Request did not select exactly one target.");

  property p_idle_quiet;
    @(posedge clk) disable iff (sys_rst)
    !req_valid |=> !resp_valid && !sel_flash && !sel_sram && !sel_rom && !periph_sel && !abort
      && external_bus_interface_sel == '0;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("Target selected without a request.");

  property p_area_split;
    @(posedge clk) disable iff (sys_rst)
    req_valid |=> fwd_addr == $past(req_addr)
      && ((|external_bus_interface_sel)
          == ($past(area) >= sad_pkg::AREA_EXT_LO && $past(area) <= sad_pkg::AREA_EXT_HI))
      && (periph_sel == ($past(area) == sad_pkg::AREA_PERIPH))
      && ((sel_flash || sel_sram || sel_rom) == ($past(area) == sad_pkg::AREA_INTERNAL && !abort));
  endproperty
  a_area_split: assert property (p_area_split) else $error("Forwarded address or area split wrong.");

  property p_ext_cs;
    @(posedge clk) disable iff (sys_rst)
    (req_valid && area >= sad_pkg::AREA_EXT_LO && area <= sad_pkg::AREA_EXT_HI)
      |=> external_bus_interface_sel == (8'h01 << ($past(area) - sad_pkg::AREA_EXT_LO));
  endproperty
  a_ext_cs: assert property (p_ext_cs) else $error("Wrong external chip select.");

  property p_int_abort;
    @(posedge clk) disable iff (sys_rst)
    (req_valid && area == sad_pkg::AREA_INTERNAL && slot > sad_pkg::SLOT_ROM) |=> abort && !sel_flash && !sel_sram && !sel_rom;
  endproperty
  a_int_abort: assert property (p_int_abort) else $error("Unused internal slot did not abort.");

  property p_periph;
    @(posedge clk) disable iff (sys_rst)
    (req_valid && area == sad_pkg::AREA_PERIPH) |=> periph_sel && !abort;
  endproperty
  a_periph: assert property (p_periph) else $error("Area 15 not routed to peripherals.");

  property p_unused_abort;
    @(posedge clk) disable iff (sys_rst)
    (req_valid && area > sad_pkg::AREA_EXT_HI && area < sad_pkg::AREA_PERIPH)
      |=> abort && resp_valid && !periph_sel && external_bus_interface_sel == '0;
  endproperty
  a_unused_abort: assert property (p_unused_abort) else $error("Unused area did not abort.");

  property p_sram_before_remap;
    @(posedge clk) disable iff (sys_rst)
    (req_valid && !remap_state && area == sad_pkg::AREA_INTERNAL && slot == sad_pkg::SLOT_BOOT) |=> !sel_sram;
  endproperty
  a_sram_before_remap: assert property (p_sram_before_remap) else $error("SRAM seen at zero before remap.");

  property p_sram_fixed_only;
    @(posedge clk) disable iff (sys_rst)
    (req_valid && !remap_state && !(area == sad_pkg::AREA_INTERNAL && slot == sad_pkg::SLOT_SRAM)) |=> !sel_sram;
  endproperty
  a_sram_fixed_only: assert property (p_sram_fixed_only) else $error("SRAM seen outside its slot.");

  property p_sram_after_remap;
    @(posedge clk) disable iff (sys_rst)
    (req_valid && remap_state && area == sad_pkg::AREA_INTERNAL
      && (slot == sad_pkg::SLOT_BOOT || slot == sad_pkg::SLOT_SRAM)) |=> sel_sram;
  endproperty
  a_sram_after_remap: assert property (p_sram_after_remap) else $error("SRAM missing after remap.");

  property p_zero_after_remap;
    @(posedge clk) disable iff (sys_rst)
    (req_valid && remap_state && area == sad_pkg::AREA_INTERNAL && slot == sad_pkg::SLOT_BOOT) |=> !sel_flash && !sel_rom;
  endproperty
  a_zero_after_remap: assert property (p_zero_after_remap) else $error("Boot memory still at zero after remap.");

  property p_rom_fixed;
    @(posedge clk) disable iff (sys_rst)
    (req_valid && area == sad_pkg::AREA_INTERNAL && slot == sad_pkg::SLOT_ROM) |=> sel_rom;
  endproperty
  a_rom_fixed: assert property (p_rom_fixed) else $error("ROM slot not decoded.");

  property p_boot_alias;
    @(posedge clk) disable iff (sys_rst)
    (req_valid && !remap_state && area == sad_pkg::AREA_INTERNAL && slot == sad_pkg::SLOT_BOOT)
      |=> sel_flash == $past(state_r.boot_sync) && sel_rom == !$past(state_r.boot_sync);
  endproperty
  a_boot_alias: assert property (p_boot_alias) else $error("Boot alias does not follow boot select.");

  property p_flash_fixed;
    @(posedge clk) disable iff (sys_rst)
    (req_valid && area == sad_pkg::AREA_INTERNAL && slot == sad_pkg::SLOT_FLASH) |=> sel_flash;
  endproperty
  a_flash_fixed: assert property (p_flash_fixed) else $error("Flash slot not decoded.");

  property p_remap_sticky;
    @(posedge clk) disable iff (sys_rst)
    (remap_cmd || remap_state) |=> remap_state [*3];
  endproperty
  a_remap_sticky: assert property (p_remap_sticky) else $error("Remap state dropped without reset.");

  property p_remap_set;
    @(posedge clk) disable iff (sys_rst)
    remap_cmd |=> remap_state;
  endproperty
  a_remap_set: assert property (p_remap_set) else $error("Remap command did not set the remap state.");

  property p_reset_clear;
    @(posedge clk)
    sys_rst |=> !remap_state && !resp_valid && !abort;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("Reset did not clear the decoder.");

  c_ext_access: cover property (@(posedge clk) disable iff (sys_rst)
    req_valid && area == sad_pkg::AREA_EXT_HI ##1 external_bus_interface_sel[7]);
  c_remap_alias: cover property (@(posedge clk) disable iff (sys_rst)
    remap_cmd ##2 req_valid && slot == sad_pkg::SLOT_BOOT && area == sad_pkg::AREA_INTERNAL);
  c_abort: cover property (@(posedge clk) disable iff (sys_rst)
    req_valid && area > sad_pkg::AREA_EXT_HI && area < sad_pkg::AREA_PERIPH ##1 abort);
  c_periph: cover property (@(posedge clk) disable iff (sys_rst)
    req_valid && area == sad_pkg::AREA_PERIPH ##1 periph_sel);
  c_boot_flash: cover property (@(posedge clk) disable iff (sys_rst)
    req_valid && !remap_state && area == sad_pkg::AREA_INTERNAL && slot == sad_pkg::SLOT_BOOT ##1 sel_flash);
endmodule // sad_decoder

// file: sad_internal_slot.sv
// Second-level decoder of the internal memory area into 1-Mbyte slots.
// Assumes the caller has already picked area zero; purely combinational.
`timescale 1ns/1ps
module sad_internal_slot (
  input  wire logic [7:0]          slot,
  input  wire logic                remap,
  input  wire logic                boot_flash,
  output sad_pkg::sad_target_type  target
);
  always_comb begin
    unique case (slot)
      sad_pkg::SLOT_BOOT: begin
        if (remap) begin
          target = sad_pkg::SAD_TGT_SRAM;
        end else if (boot_flash) begin
          target = sad_pkg::SAD_TGT_FLASH;
        end else begin
          target = sad_pkg::SAD_TGT_ROM;
        end
      end
      sad_pkg::SLOT_FLASH: target = sad_pkg::SAD_TGT_FLASH;
      sad_pkg::SLOT_SRAM:  target = sad_pkg::SAD_TGT_SRAM;
      sad_pkg::SLOT_ROM:   target = sad_pkg::SAD_TGT_ROM;
      default:             target = sad_pkg::SAD_TGT_NONE;
    endcase
  end
endmodule // sad_internal_slot

// file: sad_pkg.sv
// Constants and types for the system address decoder.
// Assumes a single clock domain and a 32-bit system bus address.
package sad_pkg;
  localparam int unsigned ADDR_W        = 32;
  localparam int unsigned AREA_MSB      = 31;
  localparam int unsigned AREA_LSB      = 28;
  localparam int unsigned SLOT_MSB      = 27;
  localparam int unsigned SLOT_LSB      = 20;
  localparam int unsigned EXT_CS_COUNT  = 8;
  localparam logic [3:0]  AREA_INTERNAL = 4'h0;
  localparam logic [3:0]  AREA_EXT_LO   = 4'h1;
  localparam logic [3:0]  AREA_EXT_HI   = 4'h8;
  localparam logic [3:0]  AREA_PERIPH   = 4'hf;
  localparam logic [7:0]  SLOT_BOOT     = 8'h00;
  localparam logic [7:0]  SLOT_FLASH    = 8'h01;
  localparam logic [7:0]  SLOT_SRAM     = 8'h02;
  localparam logic [7:0]  SLOT_ROM      = 8'h03;

  typedef enum logic [1:0] {
    SAD_TGT_NONE,
    SAD_TGT_FLASH,
    SAD_TGT_SRAM,
    SAD_TGT_ROM
  } sad_target_type;
endpackage

// file: testbench.sv
// Self-checking bench for the system address decoder.
// Assumes a 200 MHz clock and inputs changed at the falling edge.
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        issue = 1'b0;
  logic [31:0] issue_addr = 32'h0;
  logic        remap_cmd = 1'b0;
  logic        boot_select_nv_bit = 1'b0;
  logic        req_valid, resp_valid, sel_flash, sel_sram, sel_rom, periph_sel, abort, remap_state;
  logic [31:0] req_addr, fwd_addr;
  logic [7:0]  external_bus_interface_sel;
  logic        rm_m = 1'b0;
  logic [31:0] last_a = 32'h0;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          seed = 30493;
  int          cycles = 0;
  initial begin
    forever #2.5 clk = ~clk;
  end
  sad_bus_master i_sad_bus_master (.clk(clk), .issue(issue), .issue_addr(issue_addr), .req_valid(req_valid),
    .req_addr(req_addr));
  sad_decoder i_sad_decoder (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .req_addr(req_addr),
    .remap_cmd(remap_cmd), .boot_select_nv_bit(boot_select_nv_bit), .resp_valid(resp_valid),
    .sel_flash(sel_flash), .sel_sram(sel_sram), .sel_rom(sel_rom),
    .external_bus_interface_sel(external_bus_interface_sel), .periph_sel(periph_sel), .abort(abort),
    .fwd_addr(fwd_addr), .remap_state(remap_state));
  wire logic [12:0] sels = {sel_flash, sel_sram, sel_rom, external_bus_interface_sel, periph_sel, abort};
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Expected selects: flash, sram, rom, external selects, peripheral, abort.
  function automatic logic [12:0] exp_sel(logic [31:0] a, logic rm, logic bt);
    logic [12:0] r;
    if (a[31:28] == 4'h0) begin
      case (a[27:20])
        8'h00:   r = rm ? 13'h0800 : (bt ? 13'h1000 : 13'h0400);
        8'h01:   r = 13'h1000;
        8'h02:   r = 13'h0800;
        8'h03:   r = 13'h0400;
        default: r = 13'h0001;
      endcase
    end else if (a[31:28] <= 4'h8) r = 13'h0001 << (a[31:28] + 1);
    else if (a[31:28] == 4'hf) r = 13'h0002;
    else r = 13'h0001;
    return r;
  endfunction
  task automatic acc(input logic [31:0] a, input logic cmd);
    logic [12:0] e;
    e = exp_sel(a, rm_m, boot_select_nv_bit);
    issue = 1'b1;
    issue_addr = a;
    last_a = a;
    remap_cmd = cmd;
    @(negedge clk);
    if (cmd) rm_m = 1'b1;
    check("resp_valid", {31'h0, resp_valid}, 32'h1);
    check("mem_selects", {29'h0, sels[12:10]}, {29'h0, e[12:10]});
    check("route_selects", {22'h0, sels[9:0]}, {22'h0, e[9:0]});
    check("fwd_addr", fwd_addr, a);
    check("remap_state", {31'h0, remap_state}, {31'h0, rm_m});
  endtask
  task automatic idle();
    issue = 1'b0;
    remap_cmd = 1'b0;
    @(negedge clk);
    check("idle", {18'h0, resp_valid, sels}, 32'h0);
    check("idle_fwd_addr", fwd_addr, ~last_a);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      test_done;
    end
  end
  initial begin
    logic [31:0] r;
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    for (int b = 0; b < 2; b++) begin
      boot_select_nv_bit = b[0];
      repeat (3) idle();
      for (int i = 0; i < 16; i++) acc({i[3:0], 28'h0}, 1'b0);
      for (int s = 0; s < 6; s++) acc({4'h0, s[7:0], 20'hfffff}, 1'b0);
      acc(32'h0fffffff, 1'b0);
      for (int k = 0; k < 60; k++) begin
        r = $random(seed);
        acc(k[0] ? r : {12'h000, r[19:0]} | {4'h0, 4'h0, 2'b00, r[21:20], 20'h0} , 1'b0);
      end
      idle();
      acc(32'h0, 1'b1);
      for (int s = 0; s < 5; s++) acc({4'h0, s[7:0], 20'h12345}, 1'b0);
      acc(32'h0, 1'b0);
      idle();
      sys_rst = 1'b1;
      rm_m = 1'b0;
      @(negedge clk);
      check("remap_state", {31'h0, remap_state}, 32'h0);
      check("reset_outputs", {18'h0, resp_valid, sels}, 32'h0);
      sys_rst = 1'b0;
    end
    idle();
    test_done;
  end
endmodule // testbench
